// file: inbound_window_pkg.sv
// constants, field layouts and types of the inbound target window block
// assumes a single 250 MHz clock domain shared by bus, link logic and internal bus
`default_nettype none
package inbound_window_pkg;
  // ----------------------------------------------------------------
  // window geometry
  // ----------------------------------------------------------------
  localparam int NUM_WIN = 6;
  localparam int ROOT_NUM_WIN = 2;
  localparam logic [2:0] WIN_IDX_LIMIT = 3'h6;
  // ----------------------------------------------------------------
  // register map (byte addresses, low 8 bits decoded)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [1:0] WIN_AREA = 2'h1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WIN_RST = 32'h0000_0000;
  localparam logic [31:0] BAR_RST = 32'h0000_0000;
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_MPS_LSB = 4;
  localparam int CTRL_MPS_MSB = 6;
  // ----------------------------------------------------------------
  // window_mask_type_enable fields
  // ----------------------------------------------------------------
  localparam int MASK_EN_BIT = 0;
  localparam int MASK_IO_BIT = 1;
  localparam int MASK_64_BIT = 2;
  localparam int SEL_LSB = 18;
  localparam int SEL_MSB = 28;
  localparam int BASE_LSB = 29;
  localparam logic [31:0] BAR_ATTR_IO = 32'h0000_0001;
  localparam logic [31:0] BAR_ATTR_MEM64 = 32'h0000_0004;
  // ----------------------------------------------------------------
  // payload limits, in dwords
  // ----------------------------------------------------------------
  localparam logic [2:0] MPS_CODE_MAX = 3'h5;
  localparam logic [11:0] MPS_UNIT_DW = 12'h020;
  localparam logic [3:0] IBUS_MAX_DW = 4'h8;
  // ----------------------------------------------------------------
  // internal bus destinations open to inbound traffic
  // ----------------------------------------------------------------
  localparam logic [31:0] AREA2_BASE = 32'h0800_0000;
  localparam logic [31:0] AREA3_BASE = 32'h0c00_0000;
  localparam logic [31:0] AREA_MASK = 32'hfc00_0000;
  localparam logic [31:0] DRAM_BASE = 32'h4000_0000;
  localparam logic [31:0] DRAM_MASK = 32'hc000_0000;
  localparam logic [31:0] SIB_A_BASE = 32'hfe00_0000;
  localparam logic [31:0] SIB_B_BASE = 32'hfe20_0000;
  localparam logic [31:0] SIB_MASK = 32'hffe0_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_ISSUE} state_type;
endpackage : inbound_window_pkg
`default_nettype wire

// file: window_match.sv
// one BAR comparator: decides whether a captured request falls in one window
// assumes bar values are already gated by init and role; the raw mask is gated through usable
`default_nettype none
module window_match (
  input wire logic [31:0] bar_lo,
  input wire logic [31:0] bar_hi,
  input wire logic [31:0] win_mask,
  input wire logic usable,
  input wire logic wide,
  input wire logic [63:0] addr,
  input wire logic addr64,
  input wire logic io,
  output logic hit
);
  wire logic [10:0] sel = win_mask[inbound_window_pkg::SEL_MSB:inbound_window_pkg::SEL_LSB];
  wire logic [31:0] cmp_mask = {3'h7, ~sel, 18'h0};
  wire logic lo_ok = ((addr[31:0] ^ bar_lo) & cmp_mask) == 32'h0;
  // a 32-bit header only reaches a 64-bit window placed in the first 4G
  wire logic hi_ok = addr64 ? (wide && addr[63:32] == bar_hi) : (!wide || bar_hi == 32'h0);
  wire logic type_ok = io == win_mask[inbound_window_pkg::MASK_IO_BIT];

  assign hit = usable && win_mask[inbound_window_pkg::MASK_EN_BIT] && type_ok && lo_ok && hi_ok;
endmodule : window_match
`default_nettype wire

// file: pcie_inbound_target_window.sv
// inbound target path: BAR match, address translation, internal bus split
// assumes link request and internal bus logic run on CLK; registers on AHB-Lite
//
// Function
// - accept requests with payload up to the configured max payload size
// - split payloads larger than one internal bus transfer into several
// - after init done, BARs show programmed window sizes and types
// - 32-bit memory window uses one BAR, 64-bit uses BAR n+1 as upper half
// - at most one 64-bit window as root port, three as endpoint
// - an I/O window always takes exactly one BAR
// - six window sets; indices 0-1 usable as root port, 0-5 as endpoint
// - window base holds the internal address the BAR region maps to
// - mask register sets size, type, enable; disabled windows never transfer
// - all windows are disabled after reset
// - 32-bit addressed packets compare against each BAR
// - 64-bit addressed packets compare against BAR n+1 and BAR n
// - a 64-bit hit at n uses only base and mask of n
// - translated bits 17:0 come from the packet address
// - translated bits 28:18 chosen per bit by the mask
// - translated bits 31:29 come from the window base
// - only area two, area three, DRAM space or sibling controllers reached
`default_nettype none
module pcie_inbound_target_window (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic ROOT_PORT,
  input wire logic CFG_BAR_WE,
  input wire logic [2:0] CFG_BAR_IDX,
  input wire logic [31:0] CFG_BAR_WDATA,
  output logic [31:0] CFG_BAR_RDATA,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [63:0] REQ_ADDR,
  input wire logic REQ_IS64,
  input wire logic REQ_IO,
  input wire logic REQ_WRITE,
  input wire logic [10:0] REQ_LEN,
  output logic REQ_UR,
  output logic REQ_DONE,
  output logic IBUS_VALID,
  input wire logic IBUS_READY,
  output logic [31:0] IBUS_ADDR,
  output logic [3:0] IBUS_LEN,
  output logic IBUS_WRITE,
  output logic [2:0] IBUS_WIN
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  inbound_window_pkg::state_type state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] base_reg [inbound_window_pkg::NUM_WIN];
  logic [31:0] mask_reg [inbound_window_pkg::NUM_WIN];
  logic [31:0] bar_reg [inbound_window_pkg::NUM_WIN];
  logic [7:0] haddr_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [15:0] ur_cnt_reg;
  logic last_hit_reg;
  logic [2:0] last_idx_reg;
  logic [63:0] req_addr_reg;
  logic req_is64_reg;
  logic req_io_reg;
  logic req_write_reg;
  logic [10:0] req_len_reg;
  logic [10:0] rem_reg;
  logic [31:0] base_q_reg;
  logic [31:0] mask_q_reg;
  logic first_reg;

  // ----------------------------------------------------------------
  // window roles and BAR images
  // ----------------------------------------------------------------
  wire logic init_done = ctrl_reg[inbound_window_pkg::CTRL_INIT_BIT];
  logic [5:0] win_ok;
  logic [5:0] is64v;
  logic [5:0] upper;
  logic [5:0] hit_vec;
  logic [31:0] bar_val [inbound_window_pkg::NUM_WIN];

  for (genvar n = 0; n < inbound_window_pkg::NUM_WIN; n++) begin : g_win
    // nothing is visible in config space before software declares init done
    assign win_ok[n] = init_done && (!ROOT_PORT || n < inbound_window_pkg::ROOT_NUM_WIN);
    if (n % 2 == 0) begin : g_even
      // 64-bit windows only start on even indices, so role caps the count
      assign is64v[n] = win_ok[n] && win_ok[n + 1] && mask_reg[n][inbound_window_pkg::MASK_EN_BIT]
        && mask_reg[n][inbound_window_pkg::MASK_64_BIT] && !mask_reg[n][inbound_window_pkg::MASK_IO_BIT];
      assign upper[n] = 1'b0;
    end else begin : g_odd
      assign is64v[n] = 1'b0;
      assign upper[n] = is64v[n - 1];
    end
    wire logic live = win_ok[n] && !upper[n] && mask_reg[n][inbound_window_pkg::MASK_EN_BIT];
    wire logic [10:0] sel = mask_reg[n][inbound_window_pkg::SEL_MSB:inbound_window_pkg::SEL_LSB];
    wire logic [31:0] wmask = upper[n] ? 32'hffff_ffff : live ? {3'h7, ~sel, 18'h0} : 32'h0;
    wire logic [31:0] attr = !live ? 32'h0 :
      mask_reg[n][inbound_window_pkg::MASK_IO_BIT] ? inbound_window_pkg::BAR_ATTR_IO :
      is64v[n] ? inbound_window_pkg::BAR_ATTR_MEM64 : 32'h0;
    assign bar_val[n] = (bar_reg[n] & wmask) | attr;
    window_match u_match (
      .bar_lo(bar_val[n]),
      .bar_hi(n < inbound_window_pkg::NUM_WIN - 1 ? bar_val[(n + 1) % inbound_window_pkg::NUM_WIN] : 32'h0),
      .win_mask(mask_reg[n]),
      .usable(win_ok[n] && !upper[n]),
      .wide(is64v[n]),
      .addr(req_addr_reg),
      .addr64(req_is64_reg),
      .io(req_io_reg),
      .hit(hit_vec[n])
    );
  end

  // ----------------------------------------------------------------
  // hit select and translation
  // ----------------------------------------------------------------
  logic [2:0] hit_idx;
  always_comb begin
    hit_idx = 3'h0;
    for (int i = inbound_window_pkg::NUM_WIN - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hit_idx = 3'(i);
      end
    end
  end
  wire logic hit_any = |hit_vec;
  wire logic [31:0] sel_base = base_reg[hit_idx];
  wire logic [31:0] sel_mask = mask_reg[hit_idx];
  wire logic [10:0] mid_sel = sel_mask[inbound_window_pkg::SEL_MSB:inbound_window_pkg::SEL_LSB];
  wire logic [10:0] mid = (mid_sel & req_addr_reg[28:18]) | (~mid_sel & sel_base[28:18]);
  wire logic [31:0] xlat = {sel_base[31:29], mid, req_addr_reg[17:0]};

  function automatic logic route_ok(input logic [31:0] a);
    route_ok = ((a & inbound_window_pkg::AREA_MASK) == inbound_window_pkg::AREA2_BASE)
      || ((a & inbound_window_pkg::AREA_MASK) == inbound_window_pkg::AREA3_BASE)
      || ((a & inbound_window_pkg::DRAM_MASK) == inbound_window_pkg::DRAM_BASE)
      || ((a & inbound_window_pkg::SIB_MASK) == inbound_window_pkg::SIB_A_BASE)
      || ((a & inbound_window_pkg::SIB_MASK) == inbound_window_pkg::SIB_B_BASE);
  endfunction : route_ok

  // ----------------------------------------------------------------
  // payload limit and chunking
  // ----------------------------------------------------------------
  wire logic [2:0] mps_raw = ctrl_reg[inbound_window_pkg::CTRL_MPS_MSB:inbound_window_pkg::CTRL_MPS_LSB];
  wire logic [2:0] mps_code = mps_raw > inbound_window_pkg::MPS_CODE_MAX ? inbound_window_pkg::MPS_CODE_MAX : mps_raw;
  wire logic [11:0] mps_dw = inbound_window_pkg::MPS_UNIT_DW << mps_code;
  wire logic len_ok = req_len_reg != 11'h0 && {1'b0, req_len_reg} <= mps_dw;
  wire logic accept_ok = hit_any && len_ok && route_ok(xlat);
  wire logic [31:0] next_addr = IBUS_ADDR + {26'h0, IBUS_LEN, 2'h0};
  wire logic [31:0] chunk_addr = state_reg == inbound_window_pkg::ST_DECODE ? xlat : next_addr;
  wire logic [10:0] chunk_rem = state_reg == inbound_window_pkg::ST_DECODE ? req_len_reg : rem_reg;
  // no chunk crosses an internal bus line boundary
  wire logic [3:0] room = inbound_window_pkg::IBUS_MAX_DW - {1'b0, chunk_addr[4:2]};
  wire logic [3:0] chunk_len = chunk_rem < {7'h0, room} ? chunk_rem[3:0] : room;
  wire logic ibus_take = IBUS_VALID && IBUS_READY;

  // ----------------------------------------------------------------
  // request sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= inbound_window_pkg::ST_IDLE;
      REQ_READY <= 1'b0;
      REQ_UR <= 1'b0;
      REQ_DONE <= 1'b0;
      IBUS_VALID <= 1'b0;
      IBUS_ADDR <= 32'h0;
      IBUS_LEN <= 4'h0;
      IBUS_WRITE <= 1'b0;
      IBUS_WIN <= 3'h0;
      rem_reg <= 11'h0;
      first_reg <= 1'b0;
      base_q_reg <= 32'h0;
      mask_q_reg <= 32'h0;
      req_addr_reg <= 64'h0;
      req_is64_reg <= 1'b0;
      req_io_reg <= 1'b0;
      req_write_reg <= 1'b0;
      req_len_reg <= 11'h0;
      ur_cnt_reg <= 16'h0;
      last_hit_reg <= 1'b0;
      last_idx_reg <= 3'h0;
    end else begin
      REQ_UR <= 1'b0;
      REQ_DONE <= 1'b0;
      unique case (state_reg)
        inbound_window_pkg::ST_IDLE: begin
          REQ_READY <= 1'b1;
          if (REQ_VALID && REQ_READY) begin
            REQ_READY <= 1'b0;
            req_addr_reg <= REQ_ADDR;
            req_is64_reg <= REQ_IS64;
            req_io_reg <= REQ_IO;
            req_write_reg <= REQ_WRITE;
            req_len_reg <= REQ_LEN;
            state_reg <= inbound_window_pkg::ST_DECODE;
          end
        end
        inbound_window_pkg::ST_DECODE: begin
          last_hit_reg <= hit_any;
          last_idx_reg <= hit_idx;
          if (accept_ok) begin
            IBUS_VALID <= 1'b1;
            IBUS_ADDR <= xlat;
            IBUS_LEN <= chunk_len;
            IBUS_WRITE <= req_write_reg;
            IBUS_WIN <= hit_idx;
            rem_reg <= req_len_reg - {7'h0, chunk_len};
            base_q_reg <= sel_base;
            mask_q_reg <= sel_mask;
            first_reg <= 1'b1;
            state_reg <= inbound_window_pkg::ST_ISSUE;
          end else begin
            REQ_UR <= 1'b1;
            ur_cnt_reg <= ur_cnt_reg + 16'h1;
            state_reg <= inbound_window_pkg::ST_IDLE;
          end
        end
        inbound_window_pkg::ST_ISSUE: begin
          if (ibus_take) begin
            first_reg <= 1'b0;
            if (rem_reg == 11'h0) begin
              IBUS_VALID <= 1'b0;
              REQ_DONE <= 1'b1;
              state_reg <= inbound_window_pkg::ST_IDLE;
            end else begin
              IBUS_ADDR <= next_addr;
              IBUS_LEN <= chunk_len;
              rem_reg <= rem_reg - {7'h0, chunk_len};
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // config space BAR port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      CFG_BAR_RDATA <= 32'h0;
      for (int i = 0; i < inbound_window_pkg::NUM_WIN; i++) begin
        bar_reg[i] <= inbound_window_pkg::BAR_RST;
      end
    end else begin
      CFG_BAR_RDATA <= CFG_BAR_IDX < inbound_window_pkg::WIN_IDX_LIMIT ? bar_val[CFG_BAR_IDX] : 32'h0;
      if (CFG_BAR_WE && CFG_BAR_IDX < inbound_window_pkg::WIN_IDX_LIMIT) begin
        bar_reg[CFG_BAR_IDX] <= CFG_BAR_WDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  wire logic ahb_go = HSEL && HTRANS[1] && HREADY;
  wire logic win_area = haddr_reg[7:6] == inbound_window_pkg::WIN_AREA && haddr_reg[5:3] < inbound_window_pkg::WIN_IDX_LIMIT;
  wire logic [2:0] reg_idx = haddr_reg[5:3];
  wire logic [31:0] stat_word = {ur_cnt_reg, 9'h0, last_idx_reg, last_hit_reg, 2'h0,
    state_reg != inbound_window_pkg::ST_IDLE};
  wire logic [31:0] rd_word = haddr_reg == inbound_window_pkg::CTRL_OFS ? ctrl_reg :
    haddr_reg == inbound_window_pkg::STAT_OFS ? stat_word :
    !win_area ? 32'h0 : haddr_reg[2] ? mask_reg[reg_idx] : base_reg[reg_idx];

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      haddr_reg <= 8'h0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h0;
      HRESP <= 1'b0;
    end else begin
      HRESP <= 1'b0;
      rd_pend_reg <= 1'b0;
      if (HREADYOUT) begin
        wr_pend_reg <= ahb_go && HWRITE;
        if (ahb_go) begin
          haddr_reg <= HADDR[7:0];
        end
        // reads wait one cycle so a write just before is seen
        if (ahb_go && !HWRITE) begin
          HREADYOUT <= 1'b0;
          rd_pend_reg <= 1'b1;
        end
      end
      if (rd_pend_reg) begin
        HRDATA <= rd_word;
        HREADYOUT <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= inbound_window_pkg::CTRL_RST;
      for (int i = 0; i < inbound_window_pkg::NUM_WIN; i++) begin
        base_reg[i] <= inbound_window_pkg::WIN_RST;
        mask_reg[i] <= inbound_window_pkg::WIN_RST;
      end
    end else if (wr_pend_reg) begin
      if (haddr_reg == inbound_window_pkg::CTRL_OFS) begin
        ctrl_reg <= HWDATA;
      end else if (win_area && haddr_reg[2]) begin
        mask_reg[reg_idx] <= HWDATA;
      end else if (win_area) begin
        base_reg[reg_idx] <= HWDATA;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  property p_low_copy;
    IBUS_VALID && first_reg |-> IBUS_ADDR[17:0] == req_addr_reg[17:0];
  endproperty
  a_low_copy: assert property (p_low_copy) else $error("low address bits not copied");

  property p_mid_sel;
    IBUS_VALID && first_reg |-> IBUS_ADDR[28:18] ==
      ((mask_q_reg[28:18] & req_addr_reg[28:18]) | (~mask_q_reg[28:18] & base_q_reg[28:18]));
  endproperty
  a_mid_sel: assert property (p_mid_sel) else $error("middle bits wrongly selected");

  property p_top_base;
    IBUS_VALID |-> IBUS_ADDR[31:29] == base_q_reg[31:29];
  endproperty
  a_top_base: assert property (p_top_base) else $error("upper bits not from base");

  property p_chunk_fit;
    IBUS_VALID |-> IBUS_LEN != 4'h0 && ({1'b0, IBUS_ADDR[4:2]} + IBUS_LEN) <= 4'h8;
  endproperty
  a_chunk_fit: assert property (p_chunk_fit) else $error("chunk too long or crosses line");

  property p_hold;
    IBUS_VALID && !IBUS_READY |=> IBUS_VALID && $stable(IBUS_ADDR) && $stable(IBUS_LEN);
  endproperty
  a_hold: assert property (p_hold) else $error("internal request dropped while stalled");

  property p_miss_ur;
    state_reg == inbound_window_pkg::ST_DECODE && !hit_any |=> REQ_UR && !IBUS_VALID;
  endproperty
  a_miss_ur: assert property (p_miss_ur) else $error("unmatched request not refused");

  property p_fit_go;
    state_reg == inbound_window_pkg::ST_DECODE && accept_ok |=> IBUS_VALID && !REQ_UR;
  endproperty
  a_fit_go: assert property (p_fit_go) else $error("legal request not issued");

  property p_route;
    IBUS_VALID |-> route_ok(IBUS_ADDR);
  endproperty
  a_route: assert property (p_route) else $error("inbound access outside allowed space");

  property p_no_upper_hit;
    (hit_vec & upper) == 6'h0;
  endproperty
  a_no_upper_hit: assert property (p_no_upper_hit) else $error("upper half of 64-bit pair matched");

  property p_hidden_bars;
    !init_done ##1 !init_done |-> CFG_BAR_RDATA == 32'h0;
  endproperty
  a_hidden_bars: assert property (p_hidden_bars) else $error("BAR visible before init done");
endmodule : pcie_inbound_target_window
`default_nettype wire

// file: ibus_target_model.sv
// internal bus target stand-in for the far side of the inbound path
// assumes chunks are offered on valid and taken at a rising edge with ready high
`default_nettype none
module ibus_target_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic valid,
  output logic ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic phase_reg;
  // ----------------------------------------
  // acceptance pacing
  // ----------------------------------------
  // slow mode stalls every other cycle so held chunks are exercised
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end
  assign ready = valid & (~slow | phase_reg);
endmodule : ibus_target_model
`default_nettype wire

// file: pcie_inbound_target_window_tb.sv
// self-checking bench: registers over AHB-Lite, BAR config port, link requests
// assumes the internal bus target model sits on the IBUS side
`default_nettype none
module pcie_inbound_target_window_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [63:0] a; logic [10:0] len; logic ur; logic [31:0] t;} row_type;
  logic CLK = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, ROOT_PORT = 1'b0, slow = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, CFG_BAR_WDATA = 32'h0, HRDATA, IBUS_ADDR, CFG_BAR_RDATA, rdv;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2, CFG_BAR_IDX = 3'h0, IBUS_WIN;
  logic CFG_BAR_WE = 1'b0, REQ_VALID = 1'b0, REQ_IS64 = 1'b0, REQ_IO = 1'b0, REQ_WRITE = 1'b0;
  logic [63:0] REQ_ADDR = 64'h0;
  logic [10:0] REQ_LEN = 11'h1;
  logic HREADY, HREADYOUT, HRESP, REQ_READY, REQ_UR, REQ_DONE, IBUS_VALID, IBUS_READY, IBUS_WRITE;
  logic [3:0] IBUS_LEN;
  int err_count = 0;
  int n_tests = 0;
  row_type rows [5] = '{'{64'h8004_1000, 11'h001, 1'b0, 32'h4014_1000},
    '{64'h8000_001c, 11'h00a, 1'b0, 32'h4010_001c}, '{64'h8000_0000, 11'h020, 1'b0, 32'h4010_0000},
    '{64'h8000_0000, 11'h021, 1'b1, 32'h0}, '{64'h9000_0000, 11'h001, 1'b1, 32'h0}};
  assign HREADY = HREADYOUT;
  always #2 CLK = ~CLK;
  pcie_inbound_target_window dut_u (.CLK, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY, .HRDATA, .HREADYOUT, .HRESP, .ROOT_PORT, .CFG_BAR_WE, .CFG_BAR_IDX, .CFG_BAR_WDATA,
    .CFG_BAR_RDATA, .REQ_VALID, .REQ_READY, .REQ_ADDR, .REQ_IS64, .REQ_IO, .REQ_WRITE, .REQ_LEN,
    .REQ_UR, .REQ_DONE, .IBUS_VALID, .IBUS_READY, .IBUS_ADDR, .IBUS_LEN, .IBUS_WRITE, .IBUS_WIN);
  ibus_target_model tgt_u (.clk(CLK), .rstn(RSTN), .slow(slow), .valid(IBUS_VALID), .ready(IBUS_READY));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic hang();
    err_count++;
    report_and_stop();
  endtask : hang
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wait_ready();
    for (int i = 0; i <= 40; i++) begin
      @(posedge CLK);
      if (HREADYOUT === 1'b1) break;
      if (i == 40) hang();
    end
  endtask : wait_ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    wait_ready();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    wait_ready();
    rd = HRDATA;
    check({31'h0, HRESP}, 32'h0);
  endtask : ahb
  // config write or read; the image is read back a cycle after the write lands
  task automatic cfg(input logic we, input logic [2:0] idx, input logic [31:0] wd);
    @(posedge CLK);
    CFG_BAR_WE <= we;
    CFG_BAR_IDX <= idx;
    CFG_BAR_WDATA <= wd;
    @(posedge CLK);
    CFG_BAR_WE <= 1'b0;
    @(posedge CLK);
    @(negedge CLK);
  endtask : cfg
  task automatic req(input logic [63:0] a, input logic is64, input logic [10:0] len, input logic ur,
                     input logic [31:0] t, input logic [2:0] w);
    logic [31:0] ea;
    logic [10:0] rem;
    logic [10:0] room;
    logic [3:0] cl;
    logic done;
    ea = t;
    rem = len;
    done = 1'b0;
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ_ADDR <= a;
    REQ_IS64 <= is64;
    REQ_LEN <= len;
    REQ_WRITE <= ~REQ_WRITE;
    for (int i = 0; i <= 40; i++) begin
      @(negedge CLK);
      if (REQ_READY === 1'b1) break;
      if (i == 40) hang();
    end
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    for (int i = 0; i <= 200 && !done; i++) begin
      @(negedge CLK);
      if (i == 200) hang();
      if (REQ_UR === 1'b1) begin
        check({31'h0, ur}, 32'h1);
        done = 1'b1;
      end else if (IBUS_VALID === 1'b1 && IBUS_READY === 1'b1) begin
        room = 11'h8 - {8'h0, ea[4:2]};
        cl = (rem < room) ? rem[3:0] : room[3:0];
        check({31'h0, ur}, 32'h0);
        check(IBUS_ADDR, ea);
        check({28'h0, IBUS_LEN}, {28'h0, cl});
        check({29'h0, IBUS_WIN}, {29'h0, w});
        check({31'h0, IBUS_WRITE}, {31'h0, REQ_WRITE});
        ea = ea + {26'h0, cl, 2'b00};
        rem = rem - {7'h0, cl};
      end else if (REQ_DONE === 1'b1) begin
        check({21'h0, rem}, 32'h0);
        done = 1'b1;
      end
    end
  endtask : req
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    check({31'h0, REQ_READY}, 32'h0);
    RSTN <= 1'b1;
    for (int n = 0; n < 6; n++) begin
      ahb(1'b0, 8'h44 + 8'(8 * n), 32'h0, rdv);
      check(rdv, 32'h0);
    end
    ahb(1'b0, 8'h3c, 32'h0, rdv);
    check(rdv, 32'h0);
    ahb(1'b1, 8'h40, 32'h4014_0000, rdv);
    ahb(1'b1, 8'h44, 32'h000c_0001, rdv);
    cfg(1'b1, 3'h0, 32'h8000_0000);
    check(CFG_BAR_RDATA, 32'h0);
    req(rows[0].a, 1'b0, 11'h1, 1'b1, 32'h0, 3'h0);
    ahb(1'b1, 8'h00, 32'h0000_0001, rdv);
    cfg(1'b0, 3'h0, 32'h0);
    check(CFG_BAR_RDATA, 32'h8000_0000);
    for (int i = 0; i < 5; i++) begin
      slow <= i[0];
      req(rows[i].a, 1'b0, rows[i].len, rows[i].ur, rows[i].t, 3'h0);
    end
    // base of the upper set is junk on purpose: it must not leak into translation
    ahb(1'b1, 8'h50, 32'h0800_0000, rdv);
    ahb(1'b1, 8'h54, 32'h000c_0005, rdv);
    ahb(1'b1, 8'h58, 32'hfe00_0000, rdv);
    cfg(1'b1, 3'h2, 32'h2000_0000);
    check(CFG_BAR_RDATA, 32'h2000_0004);
    cfg(1'b1, 3'h3, 32'h0000_0001);
    check(CFG_BAR_RDATA, 32'h0000_0001);
    req(64'h1_2004_0100, 1'b1, 11'h2, 1'b0, 32'h0804_0100, 3'h2);
    ROOT_PORT <= 1'b1;
    req(64'h1_2004_0100, 1'b1, 11'h2, 1'b1, 32'h0, 3'h2);
    ROOT_PORT <= 1'b0;
    ahb(1'b1, 8'h40, 32'h2000_0000, rdv);
    req(rows[0].a, 1'b0, 11'h1, 1'b1, 32'h0, 3'h0);
    ahb(1'b1, 8'h40, 32'h4014_0000, rdv);
    ahb(1'b1, 8'h44, 32'h000c_0000, rdv);
    req(rows[0].a, 1'b0, 11'h1, 1'b1, 32'h0, 3'h0);
    cfg(1'b0, 3'h0, 32'h0);
    check(CFG_BAR_RDATA, 32'h0);
    ahb(1'b0, 8'h04, 32'h0, rdv);
    check(rdv, 32'h0006_0000);
    // i/o window at index 4 answers an i/o request
    ahb(1'b1, 8'h60, 32'h4000_0000, rdv);
    ahb(1'b1, 8'h64, 32'h000c_0003, rdv);
    cfg(1'b1, 3'h4, 32'h0010_0000);
    check(CFG_BAR_RDATA, 32'h0010_0001);
    @(posedge CLK);
    REQ_IO <= 1'b1;
    req(64'h0010_0040, 1'b0, 11'h1, 1'b0, 32'h4000_0040, 3'h4);
    // reset in mid-run must disable the window at index 4 again
    @(posedge CLK);
    REQ_IO <= 1'b0;
    RSTN <= 1'b0;
    @(posedge CLK);
    check({31'h0, REQ_READY}, 32'h0);
    RSTN <= 1'b1;
    ahb(1'b0, 8'h64, 32'h0, rdv);
    check(rdv, 32'h0);
    report_and_stop();
  end
endmodule : pcie_inbound_target_window_tb
`default_nettype wire
